// ### dcs_init_seq.sv
// power-up timing sequencer of the ddr controller
`timescale 1ns/1ns
`default_nettype none
`include "dcs_params.svh"
module dcs_init_seq #(
  parameter logic [15:0] RESET_CYC = 16'd20000,
  parameter logic [15:0] CKE_CYC = 16'd50000,
  parameter logic [15:0] CMD_CYC = 16'd40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  dcs_seq_if.seq sif
);
  dcs_pkg::dcs_seq_t s; // registered state
  dcs_pkg::dcs_seq_t n; // next state
  // ----------------------------------------------------------
  // sequence: reset low, cke low, first-command wait, done
  // ----------------------------------------------------------
  always_comb begin
    n = s;
    n.cnt = s.cnt + 16'h0001;
    case (s.st)
      dcs_pkg::ST_IDLE, dcs_pkg::ST_DONE: begin
        n.cnt = 16'h0000;
        // restart allowed once finished
        if (sif.start) begin
          n.st = dcs_pkg::ST_RST;
        end
      end
      dcs_pkg::ST_RST: begin
        // memory reset held for its least time
        if (s.cnt == RESET_CYC - 16'h0001) begin
          n.st = dcs_pkg::ST_CKE;
          n.cnt = 16'h0000;
        end
      end
      dcs_pkg::ST_CKE: begin
        // cke kept low after reset release
        if (s.cnt == CKE_CYC - 16'h0001) begin
          n.st = dcs_pkg::ST_CMD;
          n.cnt = 16'h0000;
        end
      end
      dcs_pkg::ST_CMD: begin
        // wait before first command, then complete
        if (s.cnt == CMD_CYC - 16'h0001) begin
          n.st = dcs_pkg::ST_DONE;
        end
      end
      default: begin
        n.st = dcs_pkg::ST_IDLE;
        n.cnt = 16'h0000;
      end
    endcase
  end
  // state register, frozen while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.st <= dcs_pkg::ST_IDLE;
      s.cnt <= 16'h0000;
    end else if (ce_i) begin
      s <= n;
    end
  end
  // decoded pin levels
  assign sif.busy = s.st[1] | s.st[2] | s.st[3];
  assign sif.done = s.st[4];
  assign sif.rst_n = s.st[2] | s.st[3] | s.st[4];
  assign sif.cke = s.st[3] | s.st[4];
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reset_hold_a: assert property (
    (s.st == dcs_pkg::ST_RST) |-> (!sif.rst_n && !sif.cke))
    else $error("memory reset not held with cke low");
  cke_time_a: assert property (
    (ce_i && s.st == dcs_pkg::ST_CKE && n.st == dcs_pkg::ST_CMD)
    |-> (s.cnt == CKE_CYC - 16'h0001))
    else $error("cke raised before its wait ended");
endmodule
`default_nettype wire

// ### dcs_mem_model.sv
// behavioural memory device that watches power-up sequencing
`timescale 1ns/1ns
`default_nettype none
module dcs_mem_model #(
  parameter int RESET_CYC = 20,
  parameter int CKE_CYC = 30
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mem_rst_n_i,
  input wire logic mem_cke_i,
  output logic dram_clk_o,
  output logic [7:0] err_o
);
  // ------------------------------------------------------------
  // counters of reset low time and cke wait time
  // ------------------------------------------------------------
  int rst_cnt; // cycles with memory reset low
  int cke_cnt; // cycles with reset released but cke low
  logic rst_q; // memory reset one cycle ago
  logic cke_q; // cke one cycle ago

  // memory clock runs free, unrelated in phase to the system clock
  initial begin
    dram_clk_o = 1'b0;
    forever #40 dram_clk_o = ~dram_clk_o;
  end

  // timing check of reset pulse and clock enable
  always @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt <= 0;
      cke_cnt <= 0;
      rst_q <= 1'b0;
      cke_q <= 1'b0;
      err_o <= 8'h00;
    end else begin
      rst_q <= mem_rst_n_i;
      cke_q <= mem_cke_i;
      // count time spent in reset, restart it at each entry
      if (!mem_rst_n_i) begin
        rst_cnt <= rst_cnt + 1;
        cke_cnt <= 0;
      end else if (!mem_cke_i) begin
        cke_cnt <= cke_cnt + 1;
      end
      // reset released too early
      if (mem_rst_n_i && !rst_q && rst_cnt < RESET_CYC) begin
        err_o <= err_o + 8'h01;
      end
      // cke raised too early or while reset is held
      if (mem_cke_i && !cke_q && (!mem_rst_n_i || cke_cnt < CKE_CYC)) begin
        err_o <= err_o + 8'h01;
      end
      if (!mem_rst_n_i && mem_rst_n_i !== rst_q) begin
        rst_cnt <= 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dcs_params.svh
// constants of the ddr configuration and start-up block
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH
// ------------------------------------------------------------
// clock and times
// ------------------------------------------------------------
`define DCS_CLK_NS 10
`define DCS_T_RESET_US 200
`define DCS_T_CKE_US 500
`define DCS_T_CMD_NS 400
`define DCS_DLL_LOCK_EDGES 9000
`define DCS_RESET_CYC ((`DCS_T_RESET_US*1000+`DCS_CLK_NS-1)/`DCS_CLK_NS)
`define DCS_CKE_CYC ((`DCS_T_CKE_US*1000+`DCS_CLK_NS-1)/`DCS_CLK_NS)
`define DCS_CMD_CYC ((`DCS_T_CMD_NS+`DCS_CLK_NS-1)/`DCS_CLK_NS)
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DCS_ADR_MODE 8'h00
`define DCS_ADR_EMR 8'h04
`define DCS_ADR_CTL 8'h08
`define DCS_ADR_STAT 8'h0C
`define DCS_ADR_DLL 8'h10
`define DCS_ADR_CALIB 8'h14
`define DCS_ADR_PHY 8'h18
`define DCS_ADR_IRQST 8'h1C
`define DCS_ADR_IRQMK 8'h20
// ------------------------------------------------------------
// fields, masks and reset values
// ------------------------------------------------------------
`define DCS_CTL_MASK 32'h03003FFB
`define DCS_CTL_RST 32'h00000400
`define DCS_CTL_INIT 2
`define DCS_MODE_BT 3
`define DCS_CL_ONLY 3'h3
`define DCS_PHY_RSTDLL 11
`define DCS_CALIB_BASE 32'h00000000
`endif

// ### dcs_pkg.sv
// types of the ddr configuration and start-up block
`default_nettype none
package dcs_pkg;
  // start-up sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RST = 5'h02,
    ST_CKE = 5'h04,
    ST_CMD = 5'h08,
    ST_DONE = 5'h10
  } dcs_seq_st_t;
  // sequencer state
  typedef struct packed {
    dcs_seq_st_t st;
    logic [15:0] cnt;
  } dcs_seq_t;
  // register file and output state
  typedef struct packed {
    logic [12:0] mode;
    logic [7:0] emr;
    logic [31:0] ctl;
    logic [11:0] dll;
    logic [31:0] calib;
    logic phy_rst;
    logic [1:0] irq_st;
    logic [1:0] irq_mk;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic start;
    logic [2:0] sync;
    logic [13:0] lock_cnt;
    logic locked;
    logic done_q;
    logic cke;
    logic rstn;
    logic [2:0] pasr;
    logic [1:0] mtype;
    logic [2:0] lp_req;
    logic traffic;
  } dcs_regs_t;
endpackage
`default_nettype wire

// ### dcs_seq_if.sv
// link between register file and start-up sequencer
`timescale 1ns/1ns
`default_nettype none
interface dcs_seq_if;
  logic start; // one-cycle start request
  logic busy; // sequence running
  logic done; // sequence finished, level
  logic cke; // memory clock enable
  logic rst_n; // memory reset, active low
  modport ctl (output start, input busy, done, cke, rst_n);
  modport seq (input start, output busy, done, cke, rst_n);
endinterface
`default_nettype wire

// ### dcs_top.sv
// ddr controller configuration registers and start-up control
// ------------------------------------------------------------
// Overview of operation
// - lpddr mode supports cas latency three only
// - mode register bits 15:13 read zero
// - extended mode bits 2:0 drive pasr lines
// - control bit 2 starts memory initialization
// - completion flag set when sequence finishes
// - control bit 0 selects ddr3
// - control bit 1 selects lpddr
// - bits 3..5 request self-refresh, power-downs
// - power-up reset and cke timing automatic
// ------------------------------------------------------------
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dcs_params.svh"
// ------------------------------------------------------------
// register map, byte offsets on the 8-bit bus address
// ------------------------------------------------------------
// 0x00 lpddr_mode_config: burst type bit 3, latency 6:4
// 0x04 lpddr_extended_mode_config: pasr field in 2:0
// 0x08 controller_control: type select, start, requests
// 0x0C controller_status: done, busy, dll locked, error
// 0x10 delay_loop_control: read count 7:0, cycles 11:8
// 0x14 calibration_target_address: unused memory word
// 0x18 phy_control_zero: phy_delay_loop_reset in bit 11
// 0x1C interrupt status: done and lock, write one clears
// 0x20 interrupt mask: same layout as the status
// the start bit is not stored: it only raises a pulse, so
// a read of the control word never shows it set, and a
// later write of other fields cannot restart the memory
module dcs_top #(
  parameter logic [15:0] RESET_CYC = 16'(`DCS_RESET_CYC),
  parameter logic [15:0] CKE_CYC = 16'(`DCS_CKE_CYC),
  parameter logic [13:0] DLL_LOCK_EDGES = 14'(`DCS_DLL_LOCK_EDGES),
  parameter logic [31:0] MEM_BASE = `DCS_CALIB_BASE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dram_clk_i,
  output logic irq_o,
  output logic mem_rst_n_o,
  output logic mem_cke_o,
  output logic [2:0] mem_pasr_o,
  output logic [1:0] mem_type_o,
  output logic [2:0] lp_req_o,
  output logic traffic_en_o,
  output logic dll_rst_o
);
  // ----------------------------------------------------------
  // state and sequencer link
  // ----------------------------------------------------------
  dcs_pkg::dcs_regs_t s; // registered state
  dcs_pkg::dcs_regs_t n; // next state
  dcs_seq_if sif(); // link to sequencer
  logic bus_req; // new bus cycle, not yet answered
  logic [7:0] adr; // word-aligned byte address
  logic [31:0] wmask; // byte lanes from sel
  logic dclk_edge; // rising edge of dram clock
  logic cfg_err; // illegal mode combination
  assign bus_req = wb_cyc_i & wb_stb_i & ~s.ack;
  assign adr = {wb_adr_i[7:2], 2'b00};
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // second and third flop only, first flop feeds second alone
  assign dclk_edge = s.sync[1] & ~s.sync[2];
  // flag modes the controller cannot run
  assign cfg_err = (s.ctl[0] & s.ctl[1])
    | (s.ctl[1] & s.mode[`DCS_MODE_BT])
    | (s.ctl[1] & (s.mode[6:4] != `DCS_CL_ONLY));

  // ----------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------
  // the sequencer owns the timed pin levels; this module only
  // registers them again so every pin leaves straight from a flop
  // restarts are refused while busy so a half-done power-up is
  // never cut short by a stray write
  dcs_init_seq #(
    .RESET_CYC(RESET_CYC),
    .CKE_CYC(CKE_CYC),
    .CMD_CYC(16'(`DCS_CMD_CYC))
  ) u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sif(sif.seq)
  );
  assign sif.start = s.start;

  // ----------------------------------------------------------
  // next-state logic: bus slave, dll lock, events, outputs
  // ----------------------------------------------------------
  always_comb begin
    logic [31:0] rd; // read data of addressed register
    logic [31:0] wd; // write data merged by byte lanes
    logic [1:0] ev; // events of this cycle
    logic [1:0] clr; // write-one-to-clear bits
    rd = 32'h00000000;
    wd = 32'h00000000;
    ev = 2'b00;
    clr = 2'b00;
    n = s;
    n.ack = 1'b0;
    n.start = 1'b0;
    // dram clock sampled through a synchroniser
    n.sync = {s.sync[1:0], dram_clk_i};
    // read mux; unmapped offsets read zero
    case (adr)
      // top bits of mode word read zero
      `DCS_ADR_MODE: rd = {19'h00000, s.mode};
      `DCS_ADR_EMR: rd = {24'h000000, s.emr};
      `DCS_ADR_CTL: rd = s.ctl;
      `DCS_ADR_STAT: rd = {28'h0000000, cfg_err, s.locked,
                           sif.busy, s.done_q};
      `DCS_ADR_DLL: rd = {20'h00000, s.dll};
      `DCS_ADR_CALIB: rd = s.calib;
      `DCS_ADR_PHY: rd = {20'h00000, s.phy_rst, 11'h000};
      `DCS_ADR_IRQST: rd = {30'h00000000, s.irq_st};
      `DCS_ADR_IRQMK: rd = {30'h00000000, s.irq_mk};
      default: rd = 32'h00000000;
    endcase
    // one answer per request; writes land at the ack edge
    if (bus_req) begin
      n.ack = 1'b1;
      n.dat = rd;
      if (wb_we_i) begin
        wd = (rd & ~wmask) | (wb_dat_i & wmask);
        case (adr)
          // only 12:0 stored, 15:13 stay zero
          `DCS_ADR_MODE: n.mode = wd[12:0];
          // pasr field kept in the low bits
          `DCS_ADR_EMR: n.emr = wd[7:0];
          `DCS_ADR_CTL: begin
            // reserved bits dropped
            n.ctl = wd & `DCS_CTL_MASK;
            // writing the init bit issues a start
            if (wb_sel_i[0] && wb_dat_i[`DCS_CTL_INIT]
                && !sif.busy) begin
              n.start = 1'b1;
            end
          end
          // delay loop count fields
          `DCS_ADR_DLL: n.dll = wd[11:0];
          // calibration target address
          `DCS_ADR_CALIB: n.calib = wd;
          `DCS_ADR_PHY: n.phy_rst = wd[`DCS_PHY_RSTDLL];
          `DCS_ADR_IRQST: clr = wb_dat_i[1:0] & wmask[1:0];
          `DCS_ADR_IRQMK: n.irq_mk = wd[1:0];
          default: n.mode = s.mode;
        endcase
      end
    end
    // dll lock counted in dram clock edges after reset
    // the dram clock is slow against clk_i, so each rising edge
    // is seen once; a faster dram clock would lose edges and
    // only lengthen the wait, never shorten it
    if (n.phy_rst) begin
      n.lock_cnt = 14'h0000;
      n.locked = 1'b0;
    end else if (!s.locked && dclk_edge) begin
      n.lock_cnt = s.lock_cnt + 14'h0001;
      if (s.lock_cnt == DLL_LOCK_EDGES - 14'h0001) begin
        n.locked = 1'b1;
        ev[1] = 1'b1;
      end
    end
    // completion flag follows the sequencer
    n.done_q = sif.done;
    ev[0] = sif.done & ~s.done_q;
    // a new event wins over a clear in the same cycle
    n.irq_st = (s.irq_st & ~clr) | ev;
    n.irq = |(n.irq_st & n.irq_mk);
    // pin copies, each from a flop
    n.cke = sif.cke;
    n.rstn = sif.rst_n;
    n.pasr = n.emr[2:0];
    n.mtype = n.ctl[1:0];
    n.lp_req = n.ctl[5:3];
    // traffic gated until completion
    n.traffic = n.done_q;
  end

  // ----------------------------------------------------------
  // state register, frozen while ce_i is low
  // ----------------------------------------------------------
  // reset forces the register defaults; every other field
  // starts at zero, so the memory stays in reset with cke low
  // until software starts the sequence
  // ce_i low holds every field, the bus answer included, so a
  // master simply sees a longer wait for its acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      // turnaround field starts at two
      s.ctl <= `DCS_CTL_RST;
      // default calibration target is range start
      s.calib <= MEM_BASE;
    end else if (ce_i) begin
      s <= n;
    end
  end

  // ----------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------
  // no output is decoded here: each is one flop of the state
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign irq_o = s.irq;
  assign mem_rst_n_o = s.rstn;
  assign mem_cke_o = s.cke;
  assign mem_pasr_o = s.pasr;
  assign mem_type_o = s.mtype;
  assign lp_req_o = s.lp_req;
  assign traffic_en_o = s.traffic;
  assign dll_rst_o = s.phy_rst;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  ack_timing_a: assert property (
    (ce_i && bus_req) |=> wb_ack_o)
    else $error("request not answered next cycle");
  mode_top_a: assert property (
    (wb_ack_o && adr == `DCS_ADR_MODE) |-> wb_dat_o[31:13] == 19'h0)
    else $error("mode word bits 31:13 not zero");
  pasr_follow_a: assert property (
    (ce_i && bus_req && wb_we_i && adr == `DCS_ADR_EMR
     && wb_sel_i[0]) |=> mem_pasr_o == $past(wb_dat_i[2:0]))
    else $error("pasr lines did not follow write");
  start_seq_a: assert property (
    (ce_i && s.start) |=> sif.busy ##1 (!ce_i || sif.busy))
    else $error("init bit did not start sequence");
  done_flag_a: assert property (
    (ce_i && sif.done && !s.done_q) |=> (s.done_q && s.irq_st[0]))
    else $error("completion not flagged");
  type_pins_a: assert property (
    mem_type_o == s.ctl[1:0] && lp_req_o == s.ctl[5:3])
    else $error("mode or request pins differ from control");
  traffic_gate_a: assert property (
    traffic_en_o |-> (s.done_q && mem_cke_o))
    else $error("traffic enabled before completion");
  lock_count_a: assert property (
    (ce_i && !s.locked && n.locked)
    |-> s.lock_cnt == DLL_LOCK_EDGES - 14'h0001)
    else $error("dll lock flagged at wrong count");
  irq_level_a: assert property (
    irq_o == |(s.irq_st & s.irq_mk))
    else $error("interrupt level wrong");
  lpddr_err_a: assert property (
    (s.ctl[1] && s.mode[6:4] != `DCS_CL_ONLY) |-> cfg_err)
    else $error("bad lpddr latency not flagged");

  // unmapped offsets answer with zero data
  unmapped_zero_a: assert property (
    (wb_ack_o && !wb_we_i && adr > `DCS_ADR_IRQMK) |-> wb_dat_o == 32'h0)
    else $error("unmapped offset read not zero");

  // reserved control bits never read back set
  ctl_rsvd_a: assert property (
    (wb_ack_o && !wb_we_i && adr == `DCS_ADR_CTL)
    |-> (wb_dat_o & ~`DCS_CTL_MASK) == 32'h0)
    else $error("reserved control bits read back set");

  // extended mode word shows only its low byte
  emr_top_a: assert property (
    (wb_ack_o && !wb_we_i && adr == `DCS_ADR_EMR)
    |-> wb_dat_o[31:8] == 24'h0)
    else $error("extended mode top bits not zero");

  // init bit written while idle raises the start pulse
  start_pulse_a: assert property (
    (ce_i && bus_req && wb_we_i && adr == `DCS_ADR_CTL && wb_sel_i[0]
     && wb_dat_i[`DCS_CTL_INIT] && !sif.busy) |=> s.start)
    else $error("init bit did not raise start");

  // init bit written while busy is refused
  busy_start_a: assert property (
    (ce_i && bus_req && wb_we_i && adr == `DCS_ADR_CTL && wb_sel_i[0]
     && wb_dat_i[`DCS_CTL_INIT] && sif.busy) |=> !s.start)
    else $error("start accepted while sequence busy");

  // lock never shown while the delay loop is held in reset
  dll_hold_a: assert property (
    dll_rst_o |-> !s.locked)
    else $error("lock shown during delay loop reset");

  // both type selects set is flagged
  both_sel_a: assert property (
    (s.ctl[0] && s.ctl[1]) |-> cfg_err)
    else $error("double type select not flagged");

  // interleaved burst in lpddr mode is flagged
  burst_err_a: assert property (
    (s.ctl[1] && s.mode[`DCS_MODE_BT]) |-> cfg_err)
    else $error("lpddr burst type not flagged");

  // clock enable low holds all state
  ce_freeze_a: assert property (
    !ce_i |=> $stable(s))
    else $error("state moved while clock enable low");

  // write one clears the done flag when no event competes
  w1c_clear_a: assert property (
    (ce_i && bus_req && wb_we_i && adr == `DCS_ADR_IRQST && wb_sel_i[0]
     && wb_dat_i[0] && !(sif.done && !s.done_q)) |=> !s.irq_st[0])
    else $error("done flag not cleared by write");

  // ----------------------------------------------------------
  // covers of the main scenarios
  // ----------------------------------------------------------
  init_done_c: cover property (ce_i && sif.done && !s.done_q);
  dll_lock_c: cover property (ce_i && !s.locked && n.locked);
  irq_fire_c: cover property ($rose(irq_o));
  w1c_clear_c: cover property ($fell(s.irq_st[0]));
  ce_stall_c: cover property (!ce_i && bus_req);
endmodule
`default_nettype wire

// ### tb_dcs_top.sv
// self-checking bench of the ddr configuration and start-up block
`timescale 1ns/1ns
`default_nettype none
`include "dcs_params.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_dcs_top;
  // ------------------------------------------------------------
  // bench signals
  // ------------------------------------------------------------
  logic clk_i, rst_i, ce_i, cyc, stb, we, ack, irq, mrst_n, cke;
  logic trf, dll_rst, dclk;
  logic [7:0] adr, merr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [2:0] pasr, lpreq;
  logic [1:0] mtype;
  int n_mismatch = 0;
  int total_checks = 0;

  // counts shortened so the power-up run stays short
  dcs_top #(.RESET_CYC(16'd20), .CKE_CYC(16'd30),
    .DLL_LOCK_EDGES(14'd8)) i_dcs_top (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .dram_clk_i(dclk), .irq_o(irq), .mem_rst_n_o(mrst_n),
    .mem_cke_o(cke), .mem_pasr_o(pasr), .mem_type_o(mtype),
    .lp_req_o(lpreq), .traffic_en_o(trf), .dll_rst_o(dll_rst));
  dcs_mem_model #(.RESET_CYC(20), .CKE_CYC(30)) i_dcs_mem_model (
    .clk_i(clk_i), .rst_i(rst_i), .mem_rst_n_i(mrst_n), .mem_cke_i(cke),
    .dram_clk_o(dclk), .err_o(merr));

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  // one classic cycle; holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) `CHK("ack", 1'b1, ack)
  endtask

  // read one register and compare it
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
    input string nm);
    wb(1'b0, a, 32'h00000000);
    `CHK(nm, e, q)
  endtask

  // write mode register, then look at the config error flag
  task automatic chk_err(input logic [31:0] m, input logic e);
    wb(1'b1, `DCS_ADR_MODE, m);
    wb(1'b0, `DCS_ADR_STAT, 32'h00000000);
    `CHK("cfg err", e, q[3])
  endtask

  // poll a status bit under a bounded count
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, `DCS_ADR_STAT, 32'h00000000);
      n++;
    end while (q[b] !== 1'b1 && n < 200);
    `CHK("stat poll", 1'b1, q[b])
  endtask

  // let registered outputs settle
  task automatic tick();
    repeat (3) @(posedge clk_i);
  endtask

  // verdict and end of run
  task automatic test_done();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and test sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // a hang costs one mismatch and ends the run
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h00000000;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`DCS_ADR_CTL, `DCS_CTL_RST, "ctl rst");
    rd_chk(`DCS_ADR_CALIB, `DCS_CALIB_BASE, "calib rst");
    wb(1'b1, 8'h24, 32'hFFFFFFFF);
    rd_chk(8'h24, 32'h00000000, "unmapped");
    wb(1'b1, `DCS_ADR_MODE, 32'hFFFFFFFF);
    rd_chk(`DCS_ADR_MODE, 32'h00001FFF, "mode top");
    wb(1'b1, `DCS_ADR_CTL, 32'h00000402);
    chk_err(32'h00001FFF, 1'b1);
    chk_err(32'h00000038, 1'b1);
    chk_err(32'h00000020, 1'b1);
    chk_err(32'h00000030, 1'b0);
    tick();
    `CHK("type lp", 2'b10, mtype)
    wb(1'b1, `DCS_ADR_CTL, 32'h00000403);
    wb(1'b0, `DCS_ADR_STAT, 32'h00000000);
    `CHK("both sel", 1'b1, q[3])
    wb(1'b1, `DCS_ADR_CTL, 32'h00000401);
    tick();
    `CHK("type d3", 2'b01, mtype)
    wb(1'b1, `DCS_ADR_CTL, 32'h00000438);
    tick();
    `CHK("lp req", 3'h7, lpreq)
    wb(1'b1, `DCS_ADR_CTL, 32'hFFFFFFFB);
    rd_chk(`DCS_ADR_CTL, `DCS_CTL_MASK, "ctl rsvd");
    wb(1'b1, `DCS_ADR_EMR, 32'hFFFFFFFD);
    rd_chk(`DCS_ADR_EMR, 32'h000000FD, "emr");
    `CHK("pasr", 3'h5, pasr)
    wb(1'b1, `DCS_ADR_CALIB, 32'h12345670);
    rd_chk(`DCS_ADR_CALIB, 32'h12345670, "calib");
    // start-up with the completion interrupt masked
    wb(1'b1, `DCS_ADR_CTL, 32'h00000402);
    wb(1'b1, `DCS_ADR_IRQMK, 32'h00000000);
    `CHK("no traffic", 1'b0, trf)
    wb(1'b1, `DCS_ADR_CTL, 32'h00000406);
    wb(1'b0, `DCS_ADR_STAT, 32'h00000000);
    `CHK("busy", 1'b1, q[1])
    `CHK("mem rst", 1'b0, mrst_n)
    poll(0);
    tick();
    `CHK("traffic", 1'b1, trf)
    `CHK("cke", 1'b1, cke)
    `CHK("mem timing", 8'h00, merr)
    `CHK("irq masked", 1'b0, irq)
    rd_chk(`DCS_ADR_CTL, 32'h00000402, "ctl back");
    wb(1'b1, `DCS_ADR_IRQMK, 32'h00000001);
    tick();
    `CHK("irq done", 1'b1, irq)
    wb(1'b1, `DCS_ADR_IRQST, 32'h00000001);
    tick();
    `CHK("irq clr", 1'b0, irq)
    // delay loop reset and released, then relock
    wb(1'b1, `DCS_ADR_PHY, 32'h00000800);
    wb(1'b1, `DCS_ADR_IRQST, 32'h00000002);
    wb(1'b1, `DCS_ADR_IRQMK, 32'h00000002);
    wb(1'b0, `DCS_ADR_STAT, 32'h00000000);
    `CHK("unlocked", 1'b0, q[2])
    `CHK("dll rst", 1'b1, dll_rst)
    `CHK("irq idle", 1'b0, irq)
    wb(1'b1, `DCS_ADR_PHY, 32'h00000000);
    poll(2);
    tick();
    `CHK("irq lock", 1'b1, irq)
    // a request made while ce_i is low waits until it rises
    ce_i <= 1'b0;
    fork
      wb(1'b1, `DCS_ADR_DLL, 32'h00000123);
      begin
        repeat (6) @(posedge clk_i);
        `CHK("ce stall", 1'b0, ack)
        ce_i <= 1'b1;
      end
    join
    rd_chk(`DCS_ADR_DLL, 32'h00000123, "ce write");
    wb(1'b1, `DCS_ADR_DLL, 32'h00000948);
    rd_chk(`DCS_ADR_DLL, 32'h00000948, "dll ctl");
    test_done();
  end
endmodule
`default_nettype wire
